// >>> bcr_pkg.sv
package bcr_pkg;
	localparam int          MV_W          = 13;
	localparam int          CODE_W        = 6;
	localparam logic [7:0]  ADDR_OUTPUT_VOLTAGE_CODE     = 8'h20;
	localparam logic [7:0]  ADDR_MODE     = 8'h21;
	localparam logic [7:0]  ADDR_RSVA     = 8'h22;
	localparam logic [7:0]  ADDR_STAT     = 8'h23;
	localparam int          RANGE_BIT     = 6;
	localparam int          MODE_BIT      = 0;
	localparam int          PG_BIT        = 1;
	localparam logic [7:0]  OUTPUT_VOLTAGE_CODE_RW_MASK  = 8'h7F;
	localparam logic [7:0]  MODE_RW_MASK  = 8'h01;
	localparam logic [7:0]  RSVA_WE_MASK  = 8'hC0;
	localparam logic [7:0]  STAT_WE_MASK  = 8'h15;
	localparam logic [7:0]  ZERO_BYTE     = 8'h00;
	localparam logic [12:0] HI_BASE_MV    = 13'h04E2;
	localparam logic [12:0] HI_STEP_MV    = 13'h0032;
	localparam logic [12:0] NA_MV         = 13'h0000;
	localparam logic [5:0]  LOW_FIRST     = 6'h12;
	localparam logic [19:0] PG_PCT        = 20'h0005E;
	localparam logic [19:0] FULL_PCT      = 20'h00064;
	localparam logic [6:0]  PAD7          = 7'h00;
	// low range targets in millivolts, zero where not available
	localparam logic [12:0] LOW_MV [0:63] = '{
		13'h000, 13'h000, 13'h000, 13'h000, 13'h000, 13'h000,
		13'h000, 13'h000, 13'h000, 13'h000, 13'h000, 13'h000,
		13'h000, 13'h000, 13'h000, 13'h000, 13'h000, 13'h000,
		13'h44C, 13'h465, 13'h47E, 13'h497, 13'h4B0, 13'h4C9,
		13'h4E7, 13'h500, 13'h519, 13'h532, 13'h54B, 13'h564,
		13'h57D, 13'h596, 13'h5AF, 13'h5C8, 13'h5E1, 13'h5FA,
		13'h613, 13'h631, 13'h64A, 13'h663, 13'h67C, 13'h695,
		13'h6AE, 13'h6C7, 13'h6E0, 13'h6F9, 13'h712, 13'h72B,
		13'h744, 13'h762, 13'h77B, 13'h794, 13'h7AD, 13'h7C6,
		13'h7DF, 13'h7F8, 13'h811, 13'h82A, 13'h843, 13'h85C,
		13'h875, 13'h88E, 13'h898, 13'h8C5
	};
endpackage : bcr_pkg

// >>> bcr_lut_if.sv
`timescale 1ns/1ns
interface bcr_lut_if;
	logic        range_sel;
	logic [5:0]  code;
	logic [12:0] target_mv;
	logic        avail;
	modport ctrl (output range_sel, code, input target_mv, avail);
	modport lut  (input range_sel, code, output target_mv, avail);
endinterface : bcr_lut_if

// >>> bcr_vout_lut.sv
`timescale 1ns/1ns
module bcr_vout_lut (
	input wire logic sys_clk,
	input wire logic srst,
	bcr_lut_if.lut   lk
);
	logic [12:0] target_d;
	logic [12:0] target_q;
	logic        avail_d;
	logic        avail_q;

	always_comb begin
		if (lk.range_sel) begin
			target_d = bcr_pkg::HI_BASE_MV
				+ ({bcr_pkg::PAD7, lk.code} * bcr_pkg::HI_STEP_MV);
			avail_d  = 1'b1;
		end else begin
			target_d = bcr_pkg::LOW_MV[lk.code];
			avail_d  = (target_d != bcr_pkg::NA_MV);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			target_q <= bcr_pkg::NA_MV;
			avail_q  <= 1'b0;
		end else begin
			target_q <= target_d;
			avail_q  <= avail_d;
		end
	end

	assign lk.target_mv = target_q;
	assign lk.avail     = avail_q;

	property p_hi_linear;
		@(posedge sys_clk) disable iff (srst)
		lk.range_sel |=> lk.avail && lk.target_mv == bcr_pkg::HI_BASE_MV
			+ ({bcr_pkg::PAD7, $past(lk.code)} * bcr_pkg::HI_STEP_MV);
	endproperty
	a_hi_linear: assert property (p_hi_linear)
		else $error("high range target wrong");

	property p_lo_na;
		@(posedge sys_clk) disable iff (srst)
		(!lk.range_sel && lk.code < bcr_pkg::LOW_FIRST) |=> !lk.avail;
	endproperty
	a_lo_na: assert property (p_lo_na)
		else $error("unavailable low code flagged valid");
endmodule : bcr_vout_lut

// >>> bcr_regs.sv
`timescale 1ns/1ns
// How it works
// - six-bit output voltage code held read/write at 0x20 bits 5:0.
// - range select at 0x20 bit 6; 0 low range, 1 high range.
// - range and code map to target millivolts; unavailable codes flagged.
// - mode bit at 0x21 bit 0; 1 forces fixed pulse-width operation.
// - power-good flag read-only at 0x23 bit 1.
// - read-only bits ignore writes and read as zero, except power-good at 0x23 bit 1.
// - power-good clears when output is below 94 percent of target.
module bcr_regs #(
	parameter logic [7:0] DEF_OUTPUT_VOLTAGE_CODE = 8'h4A,
	parameter logic [7:0] DEF_MODE = 8'h00,
	parameter logic [7:0] DEF_RSVA = 8'h00,
	parameter logic [7:0] DEF_STAT = 8'h00
) (
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic [12:0] out_sense_mv,
	output logic      [5:0]  output_voltage_code,
	output logic             reference_range_select,
	output logic             forced_pwm,
	output logic      [12:0] target_mv,
	output logic             target_valid,
	output logic             power_good
);
	logic [7:0]  output_voltage_code_d;
	logic [7:0]  output_voltage_code_q;
	logic [7:0]  mode_d;
	logic [7:0]  mode_q;
	logic [7:0]  rsva_d;
	logic [7:0]  rsva_q;
	logic [7:0]  stat_d;
	logic [7:0]  stat_q;
	logic        pg_d;
	logic        pg_q;
	logic [7:0]  rdata_d;
	logic [7:0]  rdata_q;
	logic [19:0] sense_scaled;
	logic [19:0] limit_scaled;

	bcr_lut_if lk ();

	bcr_vout_lut u_lut (
		.sys_clk (sys_clk),
		.srst    (srst),
		.lk      (lk.lut)
	);

	assign lk.range_sel = output_voltage_code_q[bcr_pkg::RANGE_BIT];
	assign lk.code      = output_voltage_code_q[bcr_pkg::CODE_W-1:0];

	always_comb begin
		output_voltage_code_d = output_voltage_code_q;
		mode_d = mode_q;
		rsva_d = rsva_q;
		stat_d = stat_q;
		if (reg_wr) begin
			case (reg_addr)
				bcr_pkg::ADDR_OUTPUT_VOLTAGE_CODE: begin
					output_voltage_code_d = reg_wdata & bcr_pkg::OUTPUT_VOLTAGE_CODE_RW_MASK;
				end
				bcr_pkg::ADDR_MODE: begin
					mode_d = reg_wdata & bcr_pkg::MODE_RW_MASK;
				end
				bcr_pkg::ADDR_RSVA: begin
					rsva_d = reg_wdata & bcr_pkg::RSVA_WE_MASK;
				end
				bcr_pkg::ADDR_STAT: begin
					stat_d = reg_wdata & bcr_pkg::STAT_WE_MASK;
				end
				default: begin
					output_voltage_code_d = output_voltage_code_q;
				end
			endcase
		end
	end

	always_comb begin
		sense_scaled = {bcr_pkg::PAD7, out_sense_mv} * bcr_pkg::FULL_PCT;
		limit_scaled = {bcr_pkg::PAD7, lk.target_mv} * bcr_pkg::PG_PCT;
		pg_d = lk.avail && (sense_scaled >= limit_scaled);
	end

	always_comb begin
		rdata_d = rdata_q;
		if (reg_rd) begin
			case (reg_addr)
				bcr_pkg::ADDR_OUTPUT_VOLTAGE_CODE: rdata_d = output_voltage_code_q;
				bcr_pkg::ADDR_MODE: rdata_d = mode_q;
				bcr_pkg::ADDR_RSVA: rdata_d = rsva_q;
				bcr_pkg::ADDR_STAT: begin
					rdata_d = stat_q;
					rdata_d[bcr_pkg::PG_BIT] = pg_q;
				end
				default: rdata_d = bcr_pkg::ZERO_BYTE;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			output_voltage_code_q  <= DEF_OUTPUT_VOLTAGE_CODE & bcr_pkg::OUTPUT_VOLTAGE_CODE_RW_MASK;
			mode_q  <= DEF_MODE & bcr_pkg::MODE_RW_MASK;
			rsva_q  <= DEF_RSVA & bcr_pkg::RSVA_WE_MASK;
			stat_q  <= DEF_STAT & bcr_pkg::STAT_WE_MASK;
			pg_q    <= 1'b0;
			rdata_q <= bcr_pkg::ZERO_BYTE;
		end else begin
			output_voltage_code_q  <= output_voltage_code_d;
			mode_q  <= mode_d;
			rsva_q  <= rsva_d;
			stat_q  <= stat_d;
			pg_q    <= pg_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata              = rdata_q;
	assign output_voltage_code    = output_voltage_code_q[bcr_pkg::CODE_W-1:0];
	assign reference_range_select = output_voltage_code_q[bcr_pkg::RANGE_BIT];
	assign forced_pwm             = mode_q[bcr_pkg::MODE_BIT];
	assign target_mv              = lk.target_mv;
	assign target_valid           = lk.avail;
	assign power_good             = pg_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	property p_code_wr;
		(reg_wr && reg_addr == bcr_pkg::ADDR_OUTPUT_VOLTAGE_CODE)
			|=> output_voltage_code == $past(reg_wdata[5:0]);
	endproperty
	a_code_wr: assert property (p_code_wr)
		else $error("voltage code not stored");

	property p_range_wr;
		(reg_wr && reg_addr == bcr_pkg::ADDR_OUTPUT_VOLTAGE_CODE)
			|=> reference_range_select == $past(reg_wdata[6]);
	endproperty
	a_range_wr: assert property (p_range_wr)
		else $error("range select not stored");

	property p_mode_wr;
		(reg_wr && reg_addr == bcr_pkg::ADDR_MODE)
			|=> forced_pwm == $past(reg_wdata[0]);
	endproperty
	a_mode_wr: assert property (p_mode_wr)
		else $error("mode bit not stored");

	property p_pg_read;
		(reg_rd && reg_addr == bcr_pkg::ADDR_STAT)
			|=> reg_rdata[1] == $past(power_good);
	endproperty
	a_pg_read: assert property (p_pg_read)
		else $error("power-good readback wrong");

	sequence s_wr_mode;
		reg_wr && reg_addr == bcr_pkg::ADDR_MODE;
	endsequence
	sequence s_rd_mode;
		reg_rd && !reg_wr && reg_addr == bcr_pkg::ADDR_MODE;
	endsequence
	property p_ro_mode;
		s_wr_mode ##1 s_rd_mode |=> reg_rdata[7:1] == 7'h00
			&& reg_rdata[0] == $past(reg_wdata[0], 2);
	endproperty
	a_ro_mode: assert property (p_ro_mode)
		else $error("read-only bits took a write");

	property p_pg_low;
		(lk.avail && sense_scaled < limit_scaled) |=> !power_good;
	endproperty
	a_pg_low: assert property (p_pg_low)
		else $error("power-good set below threshold");

	property p_rst_dflt;
		disable iff (1'b0)
		srst |=> output_voltage_code == DEF_OUTPUT_VOLTAGE_CODE[5:0]
			&& forced_pwm == DEF_MODE[0] && !power_good;
	endproperty
	a_rst_dflt: assert property (p_rst_dflt)
		else $error("reset defaults not loaded");
endmodule : bcr_regs

// >>> bcr_host.sv
`timescale 1ns/1ns
module bcr_host #(
	parameter logic [7:0] DEF_RSVA = 8'h00,
	parameter logic [7:0] DEF_STAT = 8'h00
) (
	input  wire logic       sys_clk,
	input  wire logic [7:0] reg_rdata,
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata,
	output logic            reg_rd
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end
	function automatic logic [7:0] exact(input logic [7:0] a, d);
		if (a == bcr_pkg::ADDR_RSVA)
			return (d & ~bcr_pkg::RSVA_WE_MASK) | DEF_RSVA;
		if (a == bcr_pkg::ADDR_STAT)
			return (d & ~bcr_pkg::STAT_WE_MASK) | DEF_STAT;
		return d;
	endfunction : exact
	task automatic wr(input logic [7:0] a, d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wdata = exact(a, d);
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~reg_wdata;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask : rd
	task automatic wr_rd(input logic [7:0] a, d, output logic [7:0] q);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wdata = exact(a, d);
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
		reg_rd = 1'b1;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~reg_wdata;
		q = reg_rdata;
	endtask : wr_rd
endmodule : bcr_host

// >>> test_buck_regulator_control_regs.sv
`timescale 1ns/1ns
module test_buck_regulator_control_regs;
	logic        sys_clk, srst, reg_wr, reg_rd, rv, pg, forced_pwm;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
	logic [12:0] out_sense_mv, target_mv;
	logic [5:0]  code, c;
	logic        target_valid, power_good;
	logic [31:0] seed = 32'h57;
	int          err_count = 0;
	int          tests_run = 0;
	logic [7:0]  ro [5] = '{8'h7F, 8'h01, 8'h00, 8'h00, 8'h00};
	logic [5:0]  lo [4] = '{6'h00, 6'h11, 6'h12, 6'h3F};
	logic [12:0] sn [3] = '{13'h0582, 13'h0581, 13'h05DC};
	bcr_regs #(.DEF_OUTPUT_VOLTAGE_CODE(8'h4A), .DEF_RSVA(8'h00),
		.DEF_STAT(8'h00)) DUT (.sys_clk(sys_clk), .srst(srst),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.out_sense_mv(out_sense_mv), .output_voltage_code(code),
		.reference_range_select(rv), .forced_pwm(forced_pwm),
		.target_mv(target_mv), .target_valid(target_valid),
		.power_good(power_good));
	bcr_host #(.DEF_RSVA(8'h00), .DEF_STAT(8'h00)) host (
		.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [12:0] exp_mv(input logic r, input logic [5:0] k);
		if (r)
			return 13'h04E2 + 13'h0032 * k;
		if (k < 6'h12)
			return 13'h0000;
		return (k == 6'h12) ? 13'h044C : 13'h08C5;
	endfunction : exp_mv
	task automatic chk(input logic [12:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test();
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test
	task automatic settle();
		repeat (3) @(negedge sys_clk);
	endtask : settle
	initial begin
		#20000;
		err_count++;
		end_of_test();
	end
	initial begin
		srst = 1'b1;
		out_sense_mv = 13'h0000;
		repeat (20) @(negedge sys_clk);
		srst = 1'b0;
		chk({rv, code}, 7'h4A);
		chk(forced_pwm, 1'b0);
		host.rd(bcr_pkg::ADDR_OUTPUT_VOLTAGE_CODE, d);
		chk(d, 8'h4A);
		settle();
		chk(target_mv, exp_mv(1'b1, 6'h0A));
		for (int i = 0; i < 5; i++) begin
			host.wr_rd(8'h20 + i[7:0], 8'hFF, d);
			chk(d, ro[i]);
			if (i == 1)
				chk(forced_pwm, 1'b1);
		end
		host.wr(bcr_pkg::ADDR_MODE, 8'h00);
		chk(forced_pwm, 1'b0);
		for (int i = 0; i < 8; i++) begin
			c = 6'(rnd() % 64);
			host.wr(bcr_pkg::ADDR_OUTPUT_VOLTAGE_CODE, {2'b01, c});
			settle();
			chk({rv, code}, {1'b1, c});
			chk(target_mv, exp_mv(1'b1, c));
		end
		for (int i = 0; i < 4; i++) begin
			host.wr(bcr_pkg::ADDR_OUTPUT_VOLTAGE_CODE, {2'b00, lo[i]});
			settle();
			chk(rv, 1'b0);
			chk(target_mv, exp_mv(1'b0, lo[i]));
			chk(target_valid, lo[i] >= 6'h12);
		end
		host.wr(bcr_pkg::ADDR_OUTPUT_VOLTAGE_CODE, 8'h45);
		for (int i = 0; i < 3; i++) begin
			out_sense_mv = sn[i];
			settle();
			pg = (sn[i] * 100 >= 1500 * 94);
			chk(power_good, pg);
			host.rd(bcr_pkg::ADDR_STAT, d);
			chk(d, {6'h00, pg, 1'b0});
		end
		host.wr(bcr_pkg::ADDR_MODE, 8'h01);
		chk(forced_pwm, 1'b1);
		srst = 1'b1;
		repeat (2) @(negedge sys_clk);
		srst = 1'b0;
		chk({rv, code}, 7'h4A);
		chk(forced_pwm, 1'b0);
		chk(power_good, 1'b0);
		settle();
		chk(target_mv, exp_mv(1'b1, 6'h0A));
		end_of_test();
	end
endmodule : test_buck_regulator_control_regs
